/* File: verilog/spc_defs.svh */
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// Register byte offsets on the APB slave.
`define SPC_OFS_CTRL_ONE 12'h000
`define SPC_OFS_CTRL_TWO 12'h004
`define SPC_OFS_STATUS 12'h008
`define SPC_OFS_DATA 12'h00c

// Reset values and writable masks.
`define SPC_CTRL_ONE_RST 16'h0000
`define SPC_CTRL_TWO_RST 16'h0000
`define SPC_CTRL_ONE_MASK 16'h1fff
`define SPC_CTRL_TWO_MASK 16'he003

// Field positions in serial_port_control_one.
`define SPC_B_CLK_DIS 12
`define SPC_B_DO_DIS 11
`define SPC_B_WIDTH 10
`define SPC_B_SMP 9
`define SPC_B_CKE 8
`define SPC_B_SELECT_PIN_ENABLE 7
`define SPC_B_CKP 6
`define SPC_B_MST 5
`define SPC_F_SEC_HI 4
`define SPC_F_SEC_LO 2
`define SPC_F_PRI_HI 1
`define SPC_F_PRI_LO 0

// Field positions in serial_port_control_two.
`define SPC_B_FRM 15
`define SPC_B_FSD 14
`define SPC_B_FPOL 13
`define SPC_B_FE 1
`define SPC_B_FIFO 0

// Field positions in the status register.
`define SPC_B_EN 15
`define SPC_B_TXF 1
`define SPC_B_RXF 0

// Buffer depth and serial timing.
`define SPC_FIFO_DEPTH 8
`define SPC_SEC_BASE 4'd8
`define SPC_DIV_MIN 10'd2
`define SPC_LAST_WORD 4'd15
`define SPC_LAST_BYTE 4'd7

`endif

/* File: verilog/spc_pkg.sv */
package spc_pkg;

    // Engine states, one-hot.
    typedef enum logic [2:0] {
        SPC_IDLE = 3'b001,
        SPC_SYNC = 3'b010,
        SPC_SHIFT = 3'b100
    } spc_state_t;

    // Pad outputs of the port: level and enable for each two-way pin.
    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
        logic ss_o;
        logic ss_oe;
    } spc_pins_t;

    // APB request as seen by the slave.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } spc_apb_req_t;

    // APB answer of the slave.
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } spc_apb_rsp_t;

endpackage

/* File: verilog/spc_top.sv */
`include "spc_defs.svh"

module spc_top
#(
    parameter int DEPTH = `SPC_FIFO_DEPTH
)
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire spc_pkg::spc_apb_req_t apb_req,
    output spc_pkg::spc_apb_rsp_t apb_rsp,
    // Serial pins, inputs from the pads.
    input wire logic serial_clock_pin_i,
    input wire logic serial_in_pin_i,
    input wire logic slave_select_pin_i,
    // Serial pins, levels and enables towards the pads.
    output spc_pkg::spc_pins_t pins
);
    import spc_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;

    // The pointers wrap by overflow, so the depth must be a power of two.
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 2.");
    end

    logic [15:0] ctrl_one_r;
    logic [15:0] ctrl_two_r;
    logic port_en_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic sck_d_r;
    spc_state_t st_r, st_nxt;
    logic [9:0] cnt_r, cnt_nxt;
    logic [3:0] bitn_r, bitn_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic samp_r, samp_nxt;
    logic pend_r, pend_nxt;
    logic [15:0] tx_mem [DEPTH];
    logic [15:0] rx_mem [DEPTH];
    logic [PW-1:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
    logic [CW-1:0] tx_cnt_r, rx_cnt_r;
    spc_pins_t pins_r, pins_nxt;
    logic tx_pop, rx_push;
    logic [15:0] rx_word;

    // Configuration fields.
    wire clk_dis = ctrl_one_r[`SPC_B_CLK_DIS];
    wire do_dis = ctrl_one_r[`SPC_B_DO_DIS];
    wire wide = ctrl_one_r[`SPC_B_WIDTH];
    wire sample_phase = ctrl_one_r[`SPC_B_SMP];
    wire select_pin_enable = ctrl_one_r[`SPC_B_SELECT_PIN_ENABLE];
    wire clock_polarity = ctrl_one_r[`SPC_B_CKP];
    wire mst = ctrl_one_r[`SPC_B_MST];
    wire [2:0] sec = ctrl_one_r[`SPC_F_SEC_HI:`SPC_F_SEC_LO];
    wire [1:0] pri = ctrl_one_r[`SPC_F_PRI_HI:`SPC_F_PRI_LO];
    wire frm = ctrl_two_r[`SPC_B_FRM];
    wire fsd = ctrl_two_r[`SPC_B_FSD];
    wire fpol = ctrl_two_r[`SPC_B_FPOL];
    wire fe = ctrl_two_r[`SPC_B_FE];
    wire fifo_en = ctrl_two_r[`SPC_B_FIFO];
    wire en = port_en_r;

    // The clock edge bit has no say once framing is on.
    wire cke = ctrl_one_r[`SPC_B_CKE] & ~frm;

    // Every pad input passes two flip-flops before any logic reads it.
    wire [2:0] pad_in = {slave_select_pin_i, serial_in_pin_i, serial_clock_pin_i};
    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                sync1_r[i] <= 1'b0;
                sync2_r[i] <= 1'b0;
            end
            else
            begin
                sync1_r[i] <= pad_in[i];
                sync2_r[i] <= sync1_r[i];
            end
        end
    end
    wire sck_s = sync2_r[0];
    wire sdi_s = sync2_r[1];
    wire ss_s = sync2_r[2];

    // Divisor: primary 64/16/4/1 by shifting, secondary eight minus code.
    wire [9:0] prim = 10'd1 << {~pri, 1'b0};
    wire [3:0] sec_div = `SPC_SEC_BASE - {1'b0, sec};
    wire [9:0] div_raw = 10'(prim * {6'd0, sec_div});
    // The invalid 1:1 pair is held at two cycles so the clock still toggles.
    wire [9:0] div_n = (div_raw < `SPC_DIV_MIN) ? `SPC_DIV_MIN : div_raw;
    wire [9:0] half = div_n >> 1;
    wire cnt_end = cnt_r == (div_n - 10'd1);

    // Master timing inside one bit time.
    wire act_phase = cke ? (cnt_r >= half) : (cnt_r < half);
    wire samp_pt = sample_phase ? cnt_end : (cnt_r == half);
    wire m_in_bit = (sample_phase && cnt_end) ? sdi_s : samp_r;

    // Slave clock edges, judged against the idle level.
    wire to_active = (sck_s == ~clock_polarity) && (sck_d_r == clock_polarity);
    wire to_idle = (sck_s == clock_polarity) && (sck_d_r == ~clock_polarity);
    wire s_shift_edge = cke ? to_idle : to_active;
    wire s_samp_edge = cke ? to_active : to_idle;

    // Selection and frame sync as seen on the select pad.
    wire sync_in_act = ss_s == fpol;
    wire slv_sel = frm ? 1'b1 : (~select_pin_enable | ~ss_s);
    wire slv_start = frm & fsd ? sync_in_act : slv_sel;
    wire last_bit = bitn_r == (wide ? `SPC_LAST_WORD : `SPC_LAST_BYTE);

    // Buffer capacity is one entry unless the FIFO is on.
    wire [CW-1:0] cap = fifo_en ? CW'(DEPTH) : CW'(1);
    wire tx_full = tx_cnt_r == cap;
    wire rx_full = rx_cnt_r == cap;
    wire tx_empty = tx_cnt_r == '0;
    wire rx_empty = rx_cnt_r == '0;
    wire [15:0] tx_head = tx_mem[tx_rp_r];
    wire [15:0] rx_head = rx_mem[rx_rp_r];

    // APB decode; the slave answers in the first access cycle.
    wire setup = apb_req.psel & ~apb_req.penable;
    wire done = apb_req.psel & apb_req.penable & pready_r;
    wire a_c1 = apb_req.paddr == `SPC_OFS_CTRL_ONE;
    wire a_c2 = apb_req.paddr == `SPC_OFS_CTRL_TWO;
    wire a_st = apb_req.paddr == `SPC_OFS_STATUS;
    wire a_dt = apb_req.paddr == `SPC_OFS_DATA;
    wire hit = a_c1 | a_c2 | a_st | a_dt;
    wire wr_ok = done & apb_req.pwrite & hit;
    wire rd_ok = done & ~apb_req.pwrite & hit;
    // A write to a full buffer is dropped; software checks the flag first.
    wire tx_push = wr_ok & a_dt & ~tx_full;
    wire rx_pop = rd_ok & a_dt & ~rx_empty;
    wire [15:0] status = {port_en_r, 13'd0, tx_full, rx_full};
    // An empty receive buffer reads as zero rather than leaking a stale entry.
    wire [15:0] rx_rd = rx_empty ? 16'h0000 : rx_head;
    wire [15:0] rd_mux = a_c1 ? ctrl_one_r : a_c2 ? ctrl_two_r : a_st ? status :
        a_dt ? rx_rd : 16'h0000;

    // Shift engine for both roles; the port enable aborts a word at once.
    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        bitn_nxt = bitn_r;
        sh_nxt = sh_r;
        samp_nxt = samp_r;
        pend_nxt = pend_r;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_word = 16'h0000;
        if (!en)
        begin
            st_nxt = SPC_IDLE;
            cnt_nxt = 10'd0;
            bitn_nxt = 4'd0;
            pend_nxt = 1'b0;
        end
        else
        begin
            unique case (st_r)
                SPC_IDLE:
                begin
                    cnt_nxt = 10'd0;
                    bitn_nxt = 4'd0;
                    pend_nxt = 1'b0;
                    if (mst && !tx_empty && (!frm || !fsd || sync_in_act))
                    begin
                        tx_pop = 1'b1;
                        sh_nxt = tx_head;
                        st_nxt = (frm && !fsd && !fe) ? SPC_SYNC : SPC_SHIFT;
                    end
                    else if (!mst && slv_start)
                    begin
                        // An empty buffer sends zeros rather than stalling the master.
                        tx_pop = ~tx_empty;
                        sh_nxt = tx_empty ? 16'h0000 : tx_head;
                        st_nxt = SPC_SHIFT;
                    end
                end
                SPC_SYNC:
                begin
                    cnt_nxt = cnt_end ? 10'd0 : cnt_r + 10'd1;
                    if (cnt_end)
                        st_nxt = SPC_SHIFT;
                end
                SPC_SHIFT:
                begin
                    if (mst)
                    begin
                        cnt_nxt = cnt_end ? 10'd0 : cnt_r + 10'd1;
                        if (samp_pt)
                            samp_nxt = sdi_s;
                        if (cnt_end)
                        begin
                            sh_nxt = {sh_r[14:0], m_in_bit};
                            bitn_nxt = bitn_r + 4'd1;
                            if (last_bit)
                            begin
                                rx_push = ~rx_full | rx_pop;
                                rx_word = wide ? {sh_r[14:0], m_in_bit} :
                                    {8'h00, sh_r[6:0], m_in_bit};
                                st_nxt = SPC_IDLE;
                            end
                        end
                    end
                    else if (!slv_sel)
                        st_nxt = SPC_IDLE;
                    else if (s_shift_edge && pend_r)
                    begin
                        sh_nxt = {sh_r[14:0], samp_r};
                        pend_nxt = 1'b0;
                    end
                    else if (s_samp_edge)
                    begin
                        samp_nxt = sdi_s;
                        pend_nxt = 1'b1;
                        bitn_nxt = bitn_r + 4'd1;
                        if (last_bit)
                        begin
                            rx_push = ~rx_full | rx_pop;
                            rx_word = wide ? {sh_r[14:0], sdi_s} :
                                {8'h00, sh_r[6:0], sdi_s};
                            st_nxt = SPC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Pad levels and enables, registered so the pads see no glitches.
    wire m_pulse = (st_r == SPC_SYNC) || (st_r == SPC_SHIFT && fe && bitn_r == 4'd0);
    wire s_pulse = (st_r == SPC_SHIFT) && (bitn_r == 4'd0);
    wire pulse = mst ? m_pulse : s_pulse;
    always_comb
    begin
        pins_nxt.sck_o = (st_r == SPC_SHIFT && mst && act_phase) ? ~clock_polarity : clock_polarity;
        pins_nxt.sck_oe = en & mst & ~clk_dis;
        pins_nxt.sdo_o = wide ? sh_r[15] : sh_r[7];
        pins_nxt.sdo_oe = en & ~do_dis;
        pins_nxt.ss_o = pulse ? fpol : ~fpol;
        pins_nxt.ss_oe = en & frm & ~fsd;
    end

    // Register file and APB answer.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_one_r <= `SPC_CTRL_ONE_RST;
            ctrl_two_r <= `SPC_CTRL_TWO_RST;
            port_en_r <= 1'b0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= setup;
            pslverr_r <= setup & ~hit;
            if (setup)
                prdata_r <= {16'h0000, rd_mux};
            if (wr_ok && a_c1)
                ctrl_one_r <= apb_req.pwdata[15:0] & `SPC_CTRL_ONE_MASK;
            if (wr_ok && a_c2)
                ctrl_two_r <= apb_req.pwdata[15:0] & `SPC_CTRL_TWO_MASK;
            if (wr_ok && a_st)
                port_en_r <= apb_req.pwdata[`SPC_B_EN];
        end
    end

    // Engine and pad registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= SPC_IDLE;
            cnt_r <= 10'd0;
            bitn_r <= 4'd0;
            sh_r <= 16'h0000;
            samp_r <= 1'b0;
            pend_r <= 1'b0;
            sck_d_r <= 1'b0;
            pins_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            bitn_r <= bitn_nxt;
            sh_r <= sh_nxt;
            samp_r <= samp_nxt;
            pend_r <= pend_nxt;
            sck_d_r <= sck_s;
            pins_r <= pins_nxt;
        end
    end

    // Transmit buffer; push and pop in one cycle leave the count unchanged.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_wp_r <= '0;
            tx_rp_r <= '0;
            tx_cnt_r <= '0;
        end
        else
        begin
            if (tx_push)
                tx_wp_r <= tx_wp_r + 1'b1;
            if (tx_pop)
                tx_rp_r <= tx_rp_r + 1'b1;
            tx_cnt_r <= tx_cnt_r + CW'(tx_push) - CW'(tx_pop);
        end
    end

    always_ff @(posedge pclk)
    begin
        if (tx_push)
            tx_mem[tx_wp_r] <= apb_req.pwdata[15:0];
        if (rx_push)
            rx_mem[rx_wp_r] <= rx_word;
    end

    // Receive buffer; a word arriving to a full buffer is discarded unless a read pops an entry in that cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_wp_r <= '0;
            rx_rp_r <= '0;
            rx_cnt_r <= '0;
        end
        else
        begin
            if (rx_push)
                rx_wp_r <= rx_wp_r + 1'b1;
            if (rx_pop)
                rx_rp_r <= rx_rp_r + 1'b1;
            rx_cnt_r <= rx_cnt_r + CW'(rx_push) - CW'(rx_pop);
        end
    end

    assign apb_rsp.pready = pready_r;
    assign apb_rsp.pslverr = pslverr_r;
    assign apb_rsp.prdata = prdata_r;
    assign pins = pins_r;

endmodule // spc_top

/* File: testbench/spc_top_checker.sv */
`include "spc_defs.svh"
module spc_top_checker
#(
    parameter int DEPTH = 8
)
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB side.
    input wire spc_pkg::spc_apb_req_t apb_req,
    input wire spc_pkg::spc_apb_rsp_t apb_rsp,
    // Pad inputs.
    input wire logic serial_clock_pin_i,
    input wire logic serial_in_pin_i,
    input wire logic slave_select_pin_i,
    // Pad outputs.
    input wire spc_pkg::spc_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import spc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] c1_r;
    logic [15:0] c2_r;
    logic en_r;
    logic [1:0] quiet_r;
    // Bus decode for the shadow copy of the control bits.
    wire setup = apb_req.psel && !apb_req.penable;
    wire wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    wire mapped = apb_req.paddr[11:4] == 8'h00 && apb_req.paddr[1:0] == 2'h0;
    wire w1 = wr && apb_req.paddr == `SPC_OFS_CTRL_ONE;
    wire w2 = wr && apb_req.paddr == `SPC_OFS_CTRL_TWO;
    wire w3 = wr && apb_req.paddr == `SPC_OFS_STATUS;
    wire mst = c1_r[`SPC_B_MST];
    // Pads lag a write by a stage or two, so pad checks wait until it is quiet.
    wire quiet = quiet_r == 2'h3;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            c1_r <= `SPC_CTRL_ONE_RST;
            c2_r <= `SPC_CTRL_TWO_RST;
            en_r <= 1'b0;
            quiet_r <= 2'h3;
        end
        else
        begin
            if (w1) c1_r <= apb_req.pwdata[15:0] & `SPC_CTRL_ONE_MASK;
            if (w2) c2_r <= apb_req.pwdata[15:0] & `SPC_CTRL_TWO_MASK;
            if (w3) en_r <= apb_req.pwdata[`SPC_B_EN];
            quiet_r <= (w1 || w2 || w3) ? 2'h0 : quiet_r + {1'b0, !quiet};
        end
    end
    AST_APB_READY: assert property (setup |=> apb_rsp.pready)
        else $error("pready missing after setup");
    AST_APB_ONLY: assert property (apb_rsp.pready |-> $past(setup))
        else $error("pready without setup");
    AST_APB_ERR: assert property (setup && !mapped |=> apb_rsp.pslverr && apb_rsp.prdata == 0)
        else $error("unmapped access not refused");
    AST_CLK_DRIVE: assert property (quiet && mst |->
        pins.sck_oe == (en_r && !c1_r[`SPC_B_CLK_DIS])) else $error("clock pad enable wrong");
    AST_DO_DRIVE: assert property (quiet && mst |->
        pins.sdo_oe == (en_r && !c1_r[`SPC_B_DO_DIS])) else $error("data pad enable wrong");
    AST_SLAVE_CLK: assert property (quiet && !mst |-> !pins.sck_oe)
        else $error("slave drives clock");
    AST_OFF_PINS: assert property (quiet && !en_r |-> !(pins.sck_oe || pins.sdo_oe || pins.ss_oe))
        else $error("disabled port drives a pad");
    AST_SYNC_IN: assert property (quiet && c2_r[`SPC_B_FRM] && c2_r[`SPC_B_FSD] |-> !pins.ss_oe)
        else $error("frame slave drives sync");
    AST_NO_FRAME: assert property (quiet && mst && !c2_r[`SPC_B_FRM] |-> !pins.ss_oe)
        else $error("sync driven without framing");
    AST_IDLE_LEVEL: assert property (quiet && !en_r |-> pins.sck_o == c1_r[`SPC_B_CKP])
        else $error("clock not at idle level");
    CV_ERR: cover property (setup && !mapped);
    CV_MST: cover property (quiet && mst && pins.sck_oe);
    CV_FRAME: cover property (pins.ss_oe && c2_r[`SPC_B_FRM]);
endmodule // spc_top_checker

/* File: testbench/spc_far_end.sv */
module spc_far_end
(
    // Clock.
    input wire logic pclk,
    // Pad outputs of the port.
    input wire spc_pkg::spc_pins_t pins,
    // Wire levels back to the port.
    output logic sck_w,
    output logic miso,
    output logic ss_w
);
    timeunit 1ns;
    timeprecision 1ps;
    import spc_pkg::*;
    logic tgl;
    // A released line has no pull, so it wanders instead of holding.
    initial tgl = 1'b0;
    always @(posedge pclk) tgl <= ~tgl;
    // The peer answers with the inverse, so a stuck input cannot pass.
    assign miso = pins.sdo_oe ? ~pins.sdo_o : tgl;
    assign sck_w = pins.sck_oe ? pins.sck_o : tgl;
    // Select held high: never selected, frame sync inactive at low polarity.
    assign ss_w = pins.ss_oe ? pins.ss_o : 1'b1;
endmodule // spc_far_end

/* File: testbench/tb_spc_top.sv */
`include "spc_defs.svh"
module tb_spc_top;
    timeunit 1ns;
    timeprecision 1ps;
    import spc_pkg::*;
    logic pclk, presetn, sck_q, smp_lvl, fpol, ss_seen, ss_first, err;
    logic [15:0] rx_sh, c1, r, r2, d, e;
    logic [31:0] q;
    logic [7:0] vals [`SPC_FIFO_DEPTH + 1];
    spc_apb_req_t rq;
    spc_apb_rsp_t rs;
    spc_pins_t pins;
    wire sck_w, miso, ss_w;
    int num_errors, total_checks, nbits, per, last, cyc, nb;
    spc_top #(.DEPTH(`SPC_FIFO_DEPTH)) uut (.pclk(pclk), .presetn(presetn), .apb_req(rq),
        .apb_rsp(rs), .serial_clock_pin_i(sck_w), .serial_in_pin_i(miso),
        .slave_select_pin_i(ss_w), .pins(pins));
    spc_far_end far (.pclk(pclk), .pins(pins), .sck_w(sck_w), .miso(miso), .ss_w(ss_w));
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // A hang counts as a mismatch.
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 100000)
        begin
            num_errors++;
            test_done();
        end
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        total_checks++;
        if (s !== x)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    // One APB transfer; holds the request until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        rq.psel <= 1'b1;
        rq.penable <= 1'b0;
        rq.pwrite <= w;
        rq.paddr <= a;
        rq.pwdata <= wd;
        @(posedge pclk);
        rq.penable <= 1'b1;
        // Only pready seen high or the bench timeout ends this wait.
        do
        begin
            @(posedge pclk);
        end
        while (rs.pready !== 1'b1);
        q = rs.prdata;
        err = rs.pslverr;
        rq.psel <= 1'b0;
        rq.penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic poll(input int b, input logic v);
        do
        begin
            apb(1'b0, `SPC_OFS_STATUS, 0);
        end
        while (q[b] !== v);
    endtask
    // Configure, enable, and note which clock level ends a data-valid edge.
    task automatic cfg(input logic [15:0] a, input logic [15:0] b);
        apb(1'b1, `SPC_OFS_CTRL_ONE, {16'h0, a});
        apb(1'b1, `SPC_OFS_CTRL_TWO, {16'h0, b});
        apb(1'b1, `SPC_OFS_STATUS, 32'h8000);
        smp_lvl = (a[`SPC_B_CKE] && !b[`SPC_B_FRM]) ? !a[`SPC_B_CKP] : a[`SPC_B_CKP];
        fpol = b[`SPC_B_FPOL];
        nbits = 0;
        ss_seen = 1'b0;
    endtask
    function automatic int ndiv(input logic [1:0] p, input logic [2:0] s);
        return (p == 2'h3 ? 1 : p == 2'h2 ? 4 : p == 2'h1 ? 16 : 64) * (8 - s);
    endfunction
    // Captures the serial output on each edge where it must be stable.
    always @(negedge pclk)
    begin
        if (pins.ss_oe === 1'b1 && pins.ss_o === fpol)
            ss_seen = 1'b1;
        if (pins.sck_o !== sck_q && pins.sck_o === smp_lvl)
        begin
            if (nbits == 0)
                ss_first = pins.ss_o;
            rx_sh = {rx_sh[14:0], pins.sdo_o};
            nbits++;
            per = cyc - last;
            last = cyc;
        end
        sck_q = pins.sck_o;
    end
    initial
    begin
        rq = '0;
        presetn = 1'b0;
        {sck_q, smp_lvl, fpol, ss_seen, ss_first, err} = '0;
        void'($urandom(88413));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SPC_OFS_CTRL_ONE, 0);
        chk("ctrl_one reset", `SPC_CTRL_ONE_RST, q);
        apb(1'b0, `SPC_OFS_CTRL_TWO, 0);
        chk("ctrl_two reset", `SPC_CTRL_TWO_RST, q);
        apb(1'b0, 12'h010, 0);
        chk("unmapped error", 1, err);
        // Random control words, kept within what software may program.
        repeat (6)
        begin
            r = $urandom;
            r2 = $urandom;
            r[5] = 1'b1;
            if (r2[15]) r[8] = 1'b0;
            if (r[1:0] == 2'h3) r[4] = 1'b0;
            apb(1'b1, `SPC_OFS_CTRL_ONE, {16'h0, r});
            apb(1'b0, `SPC_OFS_CTRL_ONE, 0);
            chk("ctrl_one rw", r & `SPC_CTRL_ONE_MASK, q);
            apb(1'b1, `SPC_OFS_CTRL_TWO, {16'h0, r2});
            apb(1'b0, `SPC_OFS_CTRL_TWO, 0);
            chk("ctrl_two rw", r2 & `SPC_CTRL_TWO_MASK, q);
            apb(1'b1, `SPC_OFS_STATUS, {16'h0, r2 & 16'h8000});
            apb(1'b0, `SPC_OFS_STATUS, 0);
            chk("status rw", r2 & 16'h8000, q);
        end
        // Every divider pair except 1:1, both widths, phases, edges and polarities.
        for (int p = 0; p < 4; p++)
            for (int s = 0; s < 8; s++)
                if (!(p == 3 && s == 7))
                begin
                    c1 = {5'h0, s[0], p[0], s[1], 1'b0, s[2], 1'b1, 3'(s), 2'(p)};
                    cfg(c1, 16'h0);
                    chk("clock idle", c1[`SPC_B_CKP], pins.sck_o);
                    d = $urandom;
                    e = c1[`SPC_B_WIDTH] ? d : {8'h0, d[7:0]};
                    nb = c1[`SPC_B_WIDTH] ? 16 : 8;
                    apb(1'b1, `SPC_OFS_DATA, {16'h0, d});
                    poll(0, 1'b1);
                    chk("bit count", nb, nbits);
                    chk("sent word", e, rx_sh & ~(16'hffff << nb));
                    chk("bit period", ndiv(2'(p), 3'(s)), per);
                    apb(1'b0, `SPC_OFS_DATA, 0);
                    if (ndiv(2'(p), 3'(s)) >= 8)
                        chk("got word", {16'h0, ~e} & {16'h0, nb == 16 ? 16'hffff : 16'h00ff}, q);
                end
        // Single buffer: a second word waits, a third is dropped.
        cfg(16'h0023, 16'h0);
        d = $urandom;
        apb(1'b1, `SPC_OFS_DATA, {24'h0, d[7:0]});
        apb(1'b1, `SPC_OFS_DATA, {24'h0, d[15:8]});
        apb(1'b0, `SPC_OFS_STATUS, 0);
        chk("single tx full", 32'h8002, q);
        apb(1'b1, `SPC_OFS_DATA, 32'h0);
        poll(0, 1'b1);
        apb(1'b0, `SPC_OFS_STATUS, 0);
        chk("single rx full", 32'h8001, q);
        repeat (80) @(posedge pclk);
        apb(1'b0, `SPC_OFS_DATA, 0);
        chk("single rx word", {24'h0, ~d[7:0]}, q);
        apb(1'b0, `SPC_OFS_STATUS, 0);
        chk("single rx read", 32'h8000, q);
        apb(1'b0, `SPC_OFS_DATA, 0);
        chk("empty read", 0, q);
        chk("single bits", 16, nbits);
        // FIFO: fill until refused, then drain.
        cfg(16'h0023, 16'h0001);
        for (int i = 0; i <= `SPC_FIFO_DEPTH; i++)
        begin
            vals[i] = $urandom;
            apb(1'b1, `SPC_OFS_DATA, {24'h0, vals[i]});
        end
        apb(1'b0, `SPC_OFS_STATUS, 0);
        chk("fifo tx full", 32'h8002, q);
        apb(1'b1, `SPC_OFS_DATA, 32'h0);
        poll(1, 1'b0);
        chk("fifo tx free", 32'h8000, q);
        poll(0, 1'b1);
        chk("fifo rx full", 32'h8001, q);
        repeat (80) @(posedge pclk);
        for (int i = 0; i < `SPC_FIFO_DEPTH; i++)
        begin
            apb(1'b0, `SPC_OFS_DATA, 0);
            chk("fifo rx word", {24'h0, ~vals[i]}, q);
            apb(1'b0, `SPC_OFS_STATUS, 0);
            chk("fifo rx flag", 32'h8000, q);
        end
        chk("fifo bits", (`SPC_FIFO_DEPTH + 1) * 8, nbits);
        // Framed master: each sync polarity and edge.
        for (int f = 0; f < 4; f++)
        begin
            cfg(16'h0023, {1'b1, 1'b0, f[1], 11'h0, f[0], 1'b0});
            apb(1'b1, `SPC_OFS_DATA, 32'h5a);
            poll(0, 1'b1);
            apb(1'b0, `SPC_OFS_DATA, 0);
            chk("sync pulse", 1, ss_seen);
            chk("sync at first bit", f[0] ? f[1] : !f[1], ss_first);
            chk("framed word", 32'h5a, rx_sh[7:0]);
        end
        // Slave with the select pin unused: the undriven clock line clocks a word in.
        cfg(16'h0000, 16'h0);
        poll(0, 1'b1);
        chk("slave rx full", 32'h8001, q);
        cfg(16'h0023, 16'hc000);
        repeat (4) @(posedge pclk);
        chk("sync input", 0, pins.ss_oe);
        cfg(16'h1823, 16'h0);
        repeat (4) @(posedge pclk);
        chk("pads released", 0, {pins.sck_oe, pins.sdo_oe});
        apb(1'b1, `SPC_OFS_STATUS, 0);
        repeat (4) @(posedge pclk);
        chk("port off", 0, {pins.sck_oe, pins.sdo_oe, pins.ss_oe});
        test_done();
    end
endmodule // tb_spc_top
bind spc_top spc_top_checker #(.DEPTH(DEPTH)) u_chk (.pclk, .presetn, .apb_req, .apb_rsp,
    .serial_clock_pin_i, .serial_in_pin_i, .slave_select_pin_i, .pins);
